// ### hdl/asacp_cfg.svh
`ifndef ASACP_CFG_SVH
`define ASACP_CFG_SVH
`define ASACP_REG_MODE     6'h00
`define ASACP_REG_PORT     6'h04
`define ASACP_REG_CH0      6'h08
`define ASACP_REG_CH1      6'h0C
`define ASACP_REG_FRAME    6'h10
`define ASACP_REG_IDLE     6'h14
`define ASACP_REG_SBC      6'h18
`define ASACP_REG_STATUS   6'h1C
`define ASACP_REG_LINK     6'h20
`define ASACP_REG_INFO     6'h24
`define ASACP_REG_TX0      6'h28
`define ASACP_REG_TX1      6'h2C
`define ASACP_REG_RX0      6'h30
`define ASACP_REG_RX1      6'h34
`define ASACP_PORT_EN      0
`define ASACP_PORT_MASTER  1
`define ASACP_PORT_FALL    2
`define ASACP_PORT_INV     3
`define ASACP_PORT_HIZ     4
`define ASACP_PORT_DIV_LSB 8
`define ASACP_DIV_RST      8'h04
`define ASACP_FRAME_RST    10'h040
`define ASACP_SBC_CHM_LSB  0
`define ASACP_SBC_RATE_LSB 2
`define ASACP_SBC_BLK_LSB  4
`define ASACP_SBC_SUB8     6
`define ASACP_SBC_LOUD     7
`define ASACP_SBC_POOL_LSB 8
`define ASACP_SBC_MTU_LSB  16
`define ASACP_SBC_OTHER    27
`define ASACP_RATE_16K     2'h0
`define ASACP_RATE_BAD     2'h3
`define ASACP_POOL_MIN     8'h02
`define ASACP_POOL_SINK    8'h36
`define ASACP_POOL_SRC     8'h39
`define ASACP_MTU_MIN      11'h104
`define ASACP_MTU_SINK     11'h320
`define ASACP_MTU_SRC      11'h3FD
`define ASACP_WB_BLOCKS    8'h0F
`define ASACP_WB_POOL      8'h1A
`define ASACP_WB_KBPS      8'h40
`define ASACP_LINK_WB      0
`define ASACP_LINK_NB      1
`define ASACP_LINK_CLOSE   2
`define ASACP_ST_ERR       0
`define ASACP_ST_REFUSED   3
`define ASACP_ST_OVER      6
`endif

// ### hdl/asacp_pkg.sv
package asacp_pkg;
  typedef enum logic [2:0] {
    ASACP_OFF        = 3'b000,
    ASACP_LOW_ENERGY = 3'b001,
    ASACP_WIDEBAND   = 3'b010,
    ASACP_SINK       = 3'b011,
    ASACP_SOURCE     = 3'b100
  } asacp_mode_type;
  typedef enum logic {
    ASACP_BUS_IDLE   = 1'b0,
    ASACP_BUS_ANSWER = 1'b1
  } asacp_bus_type;
endpackage

// ### hdl/asacp_port_if.sv
`timescale 1ns/100ps
interface asacp_port_if;
  logic        enable;
  logic        master;
  logic        edge_fall;
  logic        invert;
  logic        hiz_force;
  logic        tx_en;
  logic        rx_en;
  logic [7:0]  half_div;
  logic [9:0]  frame_len;
  logic [9:0]  idle_start;
  logic [9:0]  idle_end;
  logic [9:0]  pos [2];
  logic [4:0]  lenm1 [2];
  logic [31:0] tx_word [2];
  logic [31:0] rx_data [2];
  logic [1:0]  rx_strobe;
  modport ctl (output enable, master, edge_fall, invert, hiz_force, tx_en, rx_en, half_div,
               frame_len, idle_start, idle_end, pos, lenm1, tx_word,
               input rx_data, rx_strobe);
  modport port (input enable, master, edge_fall, invert, hiz_force, tx_en, rx_en, half_div,
                frame_len, idle_start, idle_end, pos, lenm1, tx_word,
                output rx_data, rx_strobe);
endinterface

// ### hdl/asacp_sbc_check.sv
`timescale 1ns/100ps
`include "asacp_cfg.svh"
module asacp_sbc_check (
  input  wire logic [31:0] cfg,
  input  wire logic        source,
  output logic             ok
);
  wire [1:0]  rate = cfg[`ASACP_SBC_RATE_LSB +: 2];
  wire [7:0]  pool = cfg[`ASACP_SBC_POOL_LSB +: 8];
  wire [10:0] mtu  = cfg[`ASACP_SBC_MTU_LSB +: 11];
  wire [7:0]  pool_max = source ? `ASACP_POOL_SRC : `ASACP_POOL_SINK;
  wire [10:0] mtu_max  = source ? `ASACP_MTU_SRC : `ASACP_MTU_SINK;
  // Every channel mode, block code, subband and allocation choice is legal
  wire rate_ok = rate != `ASACP_RATE_BAD; // RULE13
  wire pool_ok = pool >= `ASACP_POOL_MIN && pool <= pool_max; // RULE14
  wire mtu_ok  = mtu >= `ASACP_MTU_MIN && mtu <= mtu_max; // RULE15
  assign ok = rate_ok & pool_ok & mtu_ok & ~cfg[`ASACP_SBC_OTHER]; // RULE12
endmodule // asacp_sbc_check

// ### hdl/asacp_serial_port.sv
`timescale 1ns/100ps
module asacp_serial_port (
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  input  wire logic   aud_clk_in,
  input  wire logic   aud_fsync_in,
  input  wire logic   aud_din,
  output logic        aud_clk_out,
  output logic        aud_clk_oe_n,
  output logic        aud_fsync_out,
  output logic        aud_fsync_oe_n,
  output logic        aud_dout,
  output logic        aud_dout_oe_n,
  asacp_port_if.port  pif
);
  function automatic logic in_win(input logic [9:0] slot, input logic [9:0] pos,
                                  input logic [4:0] lenm1);
    in_win = slot >= pos && {1'b0, slot} <= {1'b0, pos} + {6'h00, lenm1};
  endfunction

  logic        clk_s1, clk_s2, fs_s1, fs_s2, din_s1, din_s2;
  logic [7:0]  div_cnt;
  logic        phase;
  logic [9:0]  per_cnt;
  logic        mclk_q, mfs_q;
  logic        clk_prev, fs_last, fs_pend, locked;
  logic [9:0]  cnt;
  logic [31:0] rx_sr [2];
  logic [31:0] tx_sr;
  wire         gen_on  = pif.enable & pif.master;
  wire         div_hit = div_cnt == pif.half_div;
  wire [9:0]   per_inc = per_cnt + 10'h001;
  // Clock parks low between idle start and idle end, data stops before it
  wire idle = pif.idle_end > pif.idle_start && per_cnt >= pif.idle_start &&
              per_cnt < pif.idle_end; // RULE18
  wire clk_lvl   = pif.master ? mclk_q : clk_s2;
  wire fs_lvl    = pif.master ? mfs_q : fs_s2;
  wire rise      = clk_lvl & ~clk_prev;
  wire fall      = ~clk_lvl & clk_prev;
  wire samp_fall = pif.edge_fall ^ pif.invert; // RULE3
  wire samp_edge = samp_fall ? fall : rise; // RULE5
  wire fs_edge   = samp_fall ? rise : fall; // RULE4
  wire fs_hit    = fs_edge & fs_lvl & ~fs_last;
  wire drv_edge  = pif.edge_fall ? rise : fall; // RULE2
  wire [9:0] slot_next = fs_pend | fs_hit ? 10'h000 : cnt + 10'h001;
  logic [1:0]  win, first, last, rx_take;
  logic [31:0] rx_word [2];
  logic [31:0] tx_algn [2];

  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    assign win[g]     = in_win(slot_next, pif.pos[g], pif.lenm1[g]); // RULE6
    assign first[g]   = slot_next == pif.pos[g];
    assign last[g]    = slot_next == pif.pos[g] + {5'h00, pif.lenm1[g]};
    assign rx_take[g] = samp_edge & (locked | fs_pend) & pif.rx_en & win[g];
    assign rx_word[g] = first[g] ? {31'h0, din_s2} : {rx_sr[g][30:0], din_s2};
    assign tx_algn[g] = pif.tx_word[g] << (5'h1F - pif.lenm1[g]);
  end

  // Channel 0 wins if the two windows were set to overlap
  wire        tx_load = win[0] ? first[0] : first[1];
  wire [31:0] tx_cur  = tx_load ? (win[0] ? tx_algn[0] : tx_algn[1]) : tx_sr;
  wire tx_on = (locked | fs_pend | fs_hit) & pif.tx_en & ~pif.hiz_force & (|win); // RULE19

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {clk_s1, clk_s2, fs_s1, fs_s2, din_s1, din_s2} <= 6'h00;
    end else begin
      {clk_s1, fs_s1, din_s1} <= {aud_clk_in, aud_fsync_in, aud_din};
      {clk_s2, fs_s2, din_s2} <= {clk_s1, fs_s1, din_s1};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
      phase   <= 1'b0;
      per_cnt <= 10'h000;
    end else if (!gen_on) begin
      div_cnt <= 8'h00;
      phase   <= 1'b0;
      per_cnt <= 10'h000;
    end else if (div_hit) begin
      div_cnt <= 8'h00;
      phase   <= ~phase;
      if (phase) begin
        per_cnt <= per_inc == pif.frame_len ? 10'h000 : per_inc;
      end
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_q         <= 1'b0;
      mfs_q          <= 1'b0;
      aud_clk_oe_n   <= 1'b1;
      aud_fsync_oe_n <= 1'b1;
    end else begin
      mclk_q         <= gen_on & phase & ~idle; // RULE18
      mfs_q          <= gen_on & per_cnt == 10'h000;
      aud_clk_oe_n   <= ~gen_on;
      aud_fsync_oe_n <= ~gen_on;
    end
  end
  assign aud_clk_out   = mclk_q;
  assign aud_fsync_out = mfs_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'b0;
      fs_last  <= 1'b0;
      fs_pend  <= 1'b0;
      locked   <= 1'b0;
      cnt      <= 10'h000;
    end else begin
      clk_prev <= clk_lvl;
      if (!pif.enable) begin
        fs_pend <= 1'b0;
        locked  <= 1'b0;
      end else if (fs_edge) begin
        fs_last <= fs_lvl; // RULE4
        if (fs_lvl & ~fs_last) begin
          fs_pend <= 1'b1;
        end
      end else if (samp_edge) begin
        cnt <= slot_next; // RULE6
        if (fs_pend) begin
          locked  <= 1'b1;
          fs_pend <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        rx_sr[c]       <= 32'h0;
        pif.rx_data[c] <= 32'h0;
      end
      pif.rx_strobe <= 2'h0;
    end else begin
      pif.rx_strobe <= rx_take & last;
      for (int c = 0; c < 2; c++) begin
        if (rx_take[c]) begin
          rx_sr[c] <= rx_word[c]; // RULE5
          if (last[c]) begin
            pif.rx_data[c] <= rx_word[c];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aud_dout      <= 1'b0;
      aud_dout_oe_n <= 1'b1;
      tx_sr         <= 32'h0;
    end else if (!pif.enable || pif.hiz_force) begin
      aud_dout_oe_n <= 1'b1;
    end else if (drv_edge) begin
      aud_dout_oe_n <= ~tx_on; // RULE1
      if (tx_on) begin
        aud_dout <= tx_cur[31];
        tx_sr    <= {tx_cur[30:0], 1'b0};
      end
    end
  end
endmodule // asacp_serial_port

// ### hdl/asacp_top.sv
// Functional notes
// RULE1: Serial data of a frame ends before that frame's clock idle period.
// RULE2: Port runs on rising or falling bit clock edge, selectable.
// RULE3: Option samples frame pulse and input data at inverted clock polarity.
// RULE4: Falling-edge master codec moves frame pulse on fall; device samples next rise.
// RULE5: In falling-edge mode input data is captured on the falling edge.
// RULE6: Two channels have own word size and bit position, timed by frame timer.
// RULE7: Only one of low energy, wideband speech, stereo streaming runs at once.
// RULE8: Wideband codec is mono, 16 kHz, loudness, 8 subbands, 15 blocks, bitpool 26.
// RULE9: Wideband voice uses the same 64 kbps air bandwidth as narrowband.
// RULE10: Device does wideband encode, decode and packet loss concealment itself.
// RULE11: One wideband link at a time; no narrowband link alongside it.
// RULE12: Streaming modes accept only SBC; other codecs stay with the host.
// RULE13: SBC allows all channel modes, 16/44.1/48 kHz, 4-16 blocks, 4/8 subbands.
// RULE14: Sink bitpool 2 to 54, source bitpool 2 to 57.
// RULE15: Sink MTU 260 to 800 bytes, source MTU 260 to 1021 bytes.
// RULE16: Host should program block length 16, loudness, 8 subbands.
// RULE17: Host should use bitpool 53 at 44.1 kHz, 51 at 48 kHz for best stereo.
// RULE18: Bit clock stops and holds low during the frame idle period.
// RULE19: Stereo sink decodes on chip and sends samples out of the serial port.
// RULE20: Unsupported or out-of-range configuration is rejected with an error flag.
`timescale 1ns/100ps
`include "asacp_cfg.svh"
module asacp_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        aud_clk_in,
  output logic             aud_clk_out,
  output logic             aud_clk_oe_n,
  input  wire logic        aud_fsync_in,
  output logic             aud_fsync_out,
  output logic             aud_fsync_oe_n,
  input  wire logic        aud_din,
  output logic             aud_dout,
  output logic             aud_dout_oe_n
);
  function automatic logic chan_fits(input logic [9:0] pos, input logic [4:0] lenm1,
                                     input logic [9:0] flen, input logic [9:0] istart,
                                     input logic [9:0] iend);
    logic [10:0] stop;
    stop      = {1'b0, pos} + {6'h00, lenm1} + 11'h001;
    chan_fits = stop <= {1'b0, flen} && (iend <= istart || stop <= {1'b0, istart});
  endfunction

  logic                      rst_s1, rst_s2;
  wire                       rst_n = rst_s2;
  asacp_pkg::asacp_bus_type  bus_state;
  asacp_pkg::asacp_mode_type mode;
  logic [27:0]               sbc_reg;
  logic                      cfg_valid, cfg_err, wb_active, link_refused, rx_over;
  logic [1:0]                rx_new;
  logic [31:0]               rx_word [2];
  logic                      sbc_ok;
  asacp_port_if              pif ();

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  // One wait state on every access keeps read data registered
  wire       req      = avs_read | avs_write;
  wire       answer   = bus_state == asacp_pkg::ASACP_BUS_ANSWER;
  wire       wr       = avs_write & answer;
  wire       rd       = avs_read & answer;
  wire [5:0] byte_adr = {avs_address, 2'b00};
  assign avs_waitrequest = req & ~answer;

  wire sel_mode  = byte_adr == `ASACP_REG_MODE;
  wire sel_port  = byte_adr == `ASACP_REG_PORT;
  wire sel_ch0   = byte_adr == `ASACP_REG_CH0;
  wire sel_ch1   = byte_adr == `ASACP_REG_CH1;
  wire sel_frame = byte_adr == `ASACP_REG_FRAME;
  wire sel_idle  = byte_adr == `ASACP_REG_IDLE;
  wire sel_sbc   = byte_adr == `ASACP_REG_SBC;
  wire sel_stat  = byte_adr == `ASACP_REG_STATUS;
  wire sel_link  = byte_adr == `ASACP_REG_LINK;
  wire sel_info  = byte_adr == `ASACP_REG_INFO;
  wire sel_tx0   = byte_adr == `ASACP_REG_TX0;
  wire sel_tx1   = byte_adr == `ASACP_REG_TX1;
  wire sel_rx0   = byte_adr == `ASACP_REG_RX0;
  wire sel_rx1   = byte_adr == `ASACP_REG_RX1;

  wire is_wide   = mode == asacp_pkg::ASACP_WIDEBAND;
  wire is_sink   = mode == asacp_pkg::ASACP_SINK;
  wire is_source = mode == asacp_pkg::ASACP_SOURCE;
  wire is_off    = mode == asacp_pkg::ASACP_OFF;

  // Switching between two running functions must pass through off
  wire [2:0] mode_req = avs_writedata[2:0];
  wire mode_ok = mode_req <= asacp_pkg::ASACP_SOURCE &&
                 (is_off || mode_req == asacp_pkg::ASACP_OFF || mode_req == mode); // RULE7
  wire mode_bad = wr & sel_mode & ~mode_ok;

  // Wideband codec settings are fixed, so only streaming modes take SBC settings
  wire sbc_accept = (is_sink | is_source) & sbc_ok; // RULE20
  wire sbc_bad    = wr & sel_sbc & ~sbc_accept; // RULE20

  // Layout is frozen while the port runs; enabling requires a legal layout
  wire layout_ok = chan_fits(pif.pos[0], pif.lenm1[0], pif.frame_len, pif.idle_start,
                             pif.idle_end) &
                   chan_fits(pif.pos[1], pif.lenm1[1], pif.frame_len, pif.idle_start,
                             pif.idle_end); // RULE1
  wire layout_wr  = wr & (sel_ch0 | sel_ch1 | sel_frame | sel_idle);
  wire layout_bad = layout_wr & pif.enable;
  wire en_req     = avs_writedata[`ASACP_PORT_EN];
  wire port_bad   = wr & sel_port & en_req & ~pif.enable & ~layout_ok; // RULE1
  wire err_set    = mode_bad | sbc_bad | layout_bad | port_bad; // RULE20

  wire open_wb  = wr & sel_link & avs_writedata[`ASACP_LINK_WB];
  wire open_nb  = wr & sel_link & avs_writedata[`ASACP_LINK_NB];
  wire close_wb = wr & sel_link & avs_writedata[`ASACP_LINK_CLOSE];
  wire refuse   = ~close_wb & ((open_wb & (~is_wide | wb_active)) | (open_nb & is_wide)); // RULE11

  wire [1:0] rd_clr  = {rd & sel_rx1, rd & sel_rx0};
  wire [1:0] rx_set  = pif.rx_strobe;
  wire       over    = |(rx_set & rx_new & ~rd_clr);
  wire       w1c     = wr & sel_stat;

  asacp_sbc_check u_check (
    .cfg    (avs_writedata),
    .source (is_source),
    .ok     (sbc_ok)
  );

  // Wideband forces the fixed voice codec, and concealment on chip while a wideband link is open
  wire [1:0] blk_code = sbc_reg[`ASACP_SBC_BLK_LSB +: 2];
  wire [7:0] blocks   = is_wide ? `ASACP_WB_BLOCKS : {3'h0, {1'b0, blk_code} + 3'h1, 2'b00}; // RULE8
  wire [7:0] pool     = is_wide ? `ASACP_WB_POOL : sbc_reg[`ASACP_SBC_POOL_LSB +: 8]; // RULE8
  wire [7:0] air_kbps = is_wide ? `ASACP_WB_KBPS : 8'h00; // RULE9
  wire       conceal  = is_wide & wb_active; // RULE10
  wire       sub8     = is_wide | sbc_reg[`ASACP_SBC_SUB8];
  wire       loud     = is_wide | sbc_reg[`ASACP_SBC_LOUD];
  wire [1:0] rate     = is_wide ? `ASACP_RATE_16K : sbc_reg[`ASACP_SBC_RATE_LSB +: 2];
  wire [1:0] chm      = is_wide ? 2'h0 : sbc_reg[`ASACP_SBC_CHM_LSB +: 2];
  wire [31:0] info_word = {1'b0, chm, rate, loud, sub8, conceal, air_kbps, pool, blocks};

  wire [31:0] port_word = {16'h0, pif.half_div, 3'h0, pif.hiz_force, pif.invert,
                           pif.edge_fall, pif.master, pif.enable};
  wire [31:0] stat_word = {22'h0, mode, rx_over, rx_new, link_refused, wb_active,
                           cfg_valid, cfg_err};
  wire [31:0] rd_mux =
    sel_mode  ? {29'h0, mode} :
    sel_port  ? port_word :
    sel_ch0   ? {11'h0, pif.lenm1[0], 6'h00, pif.pos[0]} :
    sel_ch1   ? {11'h0, pif.lenm1[1], 6'h00, pif.pos[1]} :
    sel_frame ? {22'h0, pif.frame_len} :
    sel_idle  ? {6'h00, pif.idle_end, 6'h00, pif.idle_start} :
    sel_sbc   ? {4'h0, sbc_reg} :
    sel_stat  ? stat_word :
    sel_info  ? info_word :
    sel_tx0   ? pif.tx_word[0] :
    sel_tx1   ? pif.tx_word[1] :
    sel_rx0   ? rx_word[0] :
    sel_rx1   ? rx_word[1] : 32'h0;

  // Streaming output only runs once a legal decoder setting is in place
  assign pif.tx_en = pif.enable & ((is_wide & wb_active) | (is_sink & cfg_valid)); // RULE19
  assign pif.rx_en = pif.enable & ((is_wide & wb_active) | (is_source & cfg_valid)); // RULE10

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state    <= asacp_pkg::ASACP_BUS_IDLE;
      avs_readdata <= 32'h0;
    end else begin
      case (bus_state)
        asacp_pkg::ASACP_BUS_IDLE: begin
          if (req) begin
            bus_state    <= asacp_pkg::ASACP_BUS_ANSWER;
            avs_readdata <= avs_read ? rd_mux : 32'h0;
          end
        end
        asacp_pkg::ASACP_BUS_ANSWER: begin
          bus_state <= asacp_pkg::ASACP_BUS_IDLE;
        end
        default: begin
          bus_state <= asacp_pkg::ASACP_BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= asacp_pkg::ASACP_OFF;
      sbc_reg   <= 28'h0;
      cfg_valid <= 1'b0;
      wb_active <= 1'b0;
    end else if (wr & sel_mode & mode_ok) begin
      mode      <= asacp_pkg::asacp_mode_type'(mode_req); // RULE7
      cfg_valid <= cfg_valid & (mode_req == mode);
      wb_active <= wb_active & (mode_req == mode);
    end else if (wr & sel_sbc & sbc_accept) begin
      sbc_reg   <= avs_writedata[27:0]; // RULE13
      cfg_valid <= 1'b1;
    end else if (close_wb) begin
      wb_active <= 1'b0;
    end else if (open_wb & is_wide) begin
      wb_active <= 1'b1; // RULE11
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pif.enable     <= 1'b0;
      pif.master     <= 1'b0;
      pif.edge_fall  <= 1'b0;
      pif.invert     <= 1'b0;
      pif.hiz_force  <= 1'b1;
      pif.half_div   <= `ASACP_DIV_RST;
    end else if (wr & sel_port) begin
      pif.enable     <= en_req & (pif.enable | layout_ok);
      pif.master     <= avs_writedata[`ASACP_PORT_MASTER];
      pif.edge_fall  <= avs_writedata[`ASACP_PORT_FALL]; // RULE2
      pif.invert     <= avs_writedata[`ASACP_PORT_INV]; // RULE3
      pif.hiz_force  <= avs_writedata[`ASACP_PORT_HIZ];
      pif.half_div   <= avs_writedata[`ASACP_PORT_DIV_LSB +: 8];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pif.frame_len  <= `ASACP_FRAME_RST;
      pif.idle_start <= 10'h000;
      pif.idle_end   <= 10'h000;
      for (int c = 0; c < 2; c++) begin
        pif.pos[c]     <= 10'h000;
        pif.lenm1[c]   <= 5'h0F;
        pif.tx_word[c] <= 32'h0;
      end
    end else begin
      if (layout_wr & ~pif.enable & sel_frame) begin
        pif.frame_len <= avs_writedata[9:0];
      end
      if (layout_wr & ~pif.enable & sel_idle) begin
        pif.idle_start <= avs_writedata[9:0];
        pif.idle_end   <= avs_writedata[25:16];
      end
      for (int c = 0; c < 2; c++) begin
        if (layout_wr & ~pif.enable & (c == 0 ? sel_ch0 : sel_ch1)) begin
          pif.pos[c]   <= avs_writedata[9:0]; // RULE6
          pif.lenm1[c] <= avs_writedata[20:16];
        end
        if (wr & (c == 0 ? sel_tx0 : sel_tx1)) begin
          pif.tx_word[c] <= avs_writedata;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_err      <= 1'b0;
      link_refused <= 1'b0;
      rx_over      <= 1'b0;
      rx_new       <= 2'h0;
      rx_word[0]   <= 32'h0;
      rx_word[1]   <= 32'h0;
    end else begin
      cfg_err      <= (cfg_err & ~(w1c & avs_writedata[`ASACP_ST_ERR])) | err_set; // RULE20
      link_refused <= (link_refused & ~(w1c & avs_writedata[`ASACP_ST_REFUSED])) | refuse;
      rx_over      <= (rx_over & ~(w1c & avs_writedata[`ASACP_ST_OVER])) | over;
      rx_new       <= (rx_new & ~rd_clr) | rx_set;
      for (int c = 0; c < 2; c++) begin
        if (rx_set[c]) begin
          rx_word[c] <= pif.rx_data[c];
        end
      end
    end
  end

  asacp_serial_port u_port (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .aud_clk_in     (aud_clk_in),
    .aud_fsync_in   (aud_fsync_in),
    .aud_din        (aud_din),
    .aud_clk_out    (aud_clk_out),
    .aud_clk_oe_n   (aud_clk_oe_n),
    .aud_fsync_out  (aud_fsync_out),
    .aud_fsync_oe_n (aud_fsync_oe_n),
    .aud_dout       (aud_dout),
    .aud_dout_oe_n  (aud_dout_oe_n),
    .pif            (pif)
  );
endmodule // asacp_top

// ### test/asacp_top_assertions.sv
`timescale 1ns/100ps
module asacp_top_assertions (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        aud_clk_out,
  input wire logic        aud_clk_oe_n,
  input wire logic        aud_dout_oe_n
);
  logic [3:0] hi;
  logic [3:0] lo;
  wire        an = (avs_read | avs_write) & !avs_waitrequest;
  // Low run saturates, so a long stop of the clock reads as frame idle
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hi <= 4'h0;
      lo <= 4'h0;
    end else begin
      hi <= aud_clk_out ? hi + 4'h1 : 4'h0;
      lo <= aud_clk_out ? 4'h0 : lo + {3'h0, lo != 4'hF};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_wait; avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
  property p_ask; $rose(avs_read | avs_write) |-> avs_waitrequest; endproperty
  a_ask: assert property (p_ask) else $error("no wait cycle");
  property p_wr; an && avs_write |-> avs_readdata == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write read data");
  property p_gap; an && avs_read && avs_address > 4'hD |-> avs_readdata == 32'h0; endproperty
  a_gap: assert property (p_gap) else $error("unmapped read");
  property p_mode; an && avs_read && avs_address == 4'h7 |-> avs_readdata[9:7] <= 3'h4; endproperty
  a_mode: assert property (p_mode) else $error("mode field");
  property p_rst; $rose(resetn) |-> aud_clk_oe_n && aud_dout_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("pin driven in reset");
  property p_hi; aud_clk_out |-> hi < 4'h5; endproperty
  a_hi: assert property (p_hi) else $error("clock high too long");
  property p_idle; !aud_clk_oe_n && lo > 4'hC |-> aud_dout_oe_n; endproperty
  a_idle: assert property (p_idle) else $error("data in idle");
  cover property (an && avs_write);
  cover property (an && avs_read);
  cover property (!aud_dout_oe_n && !aud_clk_oe_n);
endmodule // asacp_top_assertions
bind asacp_top asacp_top_assertions chk (.core_clk, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .aud_clk_out, .aud_clk_oe_n, .aud_dout_oe_n);

// ### test/asacp_codec_model.sv
`timescale 1ns/100ps
module asacp_codec_model (
  input  wire logic   aud_dout,
  input  wire logic   aud_dout_oe_n,
  output logic        aud_clk_in,
  output logic        aud_fsync_in,
  output logic        aud_din,
  output logic [31:0] cap,
  output logic        done
);
  initial begin
    aud_clk_in = 1'b0;
    aud_fsync_in = 1'b0;
    aud_din = 1'b0;
    cap = 32'h0;
    done = 1'b0;
  end
  // Clock stands low between frames; a released line shows the inverse
  task automatic run(input logic [23:0] w, input logic fall);
    int s;
    #10 s = 0;
    done = 1'b0;
    cap = 32'h0;
    for (int i = 0; i < 52; i++) begin
      #200 aud_clk_in = ~aud_clk_in;
      if (aud_clk_in != fall) begin
        if (s > 0 && s < 25) cap = {cap[30:0], aud_dout_oe_n ? ~cap[0] : aud_dout};
        aud_fsync_in = (s == 0);
        s++;
      end else if (s > 0 && s < 25) aud_din = w[24 - s];
    end
    aud_din = ~aud_din;
    done = 1'b1;
  endtask
endmodule // asacp_codec_model

// ### test/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin ev = (e); checks_done++; if ((a) !== ev) begin miscompares++; \
  $display("FAIL %0t got %h want %h", $time, a, ev); end end
module tb_top;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, cap, w, ev;
  logic        avs_waitrequest, aud_clk_out, aud_clk_oe_n, aud_fsync_out, aud_fsync_oe_n;
  logic        aud_dout, aud_dout_oe_n, aud_clk_in, aud_fsync_in, aud_din, done;
  logic [31:0] q[$], cq[$];
  logic [15:0] t0, t1;
  int          miscompares = 0;
  int          checks_done = 0;
  int          seed = 34769;
  int          cyc = 0;
  always #25 core_clk = ~core_clk;
  asacp_top uut (.core_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .aud_clk_in, .aud_clk_out, .aud_clk_oe_n, .aud_fsync_in,
    .aud_fsync_out, .aud_fsync_oe_n, .aud_din, .aud_dout, .aud_dout_oe_n);
  asacp_codec_model cdc (.aud_dout, .aud_dout_oe_n, .aud_clk_in, .aud_fsync_in, .aud_din,
    .cap, .done);
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rdx(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    acc(1'b0, a, 32'h0);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
    if (avs_read && avs_waitrequest === 1'b0) `CHK(avs_readdata, q.pop_front())
  end
  always @(posedge done) if (cq.size() > 0) `CHK(cap, cq.pop_front())
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rdx(4'h1, 32'h410);
    rdx(4'h2, 32'hF0000);
    rdx(4'hF, 32'h0);
    acc(1'b1, 4'h0, 32'h2);
    rdx(4'h9, 32'h6401A0F);
    // Stream setup in voice mode is refused
    acc(1'b1, 4'h6, 32'h10FFFF);
    acc(1'b1, 4'h8, 32'h1);
    acc(1'b1, 4'h8, 32'h2);
    rdx(4'h7, 32'h10D);
    rdx(4'h9, 32'h7401A0F);
    acc(1'b1, 4'h7, 32'h9);
    acc(1'b1, 4'h0, 32'h4);
    rdx(4'h7, 32'h105);
    acc(1'b1, 4'h3, 32'h70010);
    for (int k = 0; k < 3; k++) begin
      {t1, t0} = $random(seed);
      w = $random(seed);
      acc(1'b1, 4'hA, {16'h0, t0});
      acc(1'b1, 4'hB, {16'h0, t1});
      acc(1'b1, 4'h1, 32'h401 | (k << 2));
      // Inverted sampling keeps the drive edge, so its output timing is not judged
      if (k < 2) cq.push_back({8'h0, t0, t1[7:0]});
      cdc.run(w[23:0], k > 0);
      rdx(4'hC, {16'h0, w[23:8]});
      rdx(4'hD, {24'h0, w[7:0]});
    end
    acc(1'b1, 4'h1, 32'h400);
    acc(1'b1, 4'h5, 32'h280018);
    acc(1'b1, 4'h4, 32'h30);
    acc(1'b1, 4'h1, 32'h403);
    repeat (1500) @(posedge core_clk);
    acc(1'b1, 4'h0, 32'h0);
    acc(1'b1, 4'h0, 32'h4);
    acc(1'b1, 4'h6, 32'h3FD35F7);
    rdx(4'h9, 32'h6E003510);
    wrap_up();
  end
endmodule // tb_top
